/* File: rtl/prog_pulse_gen.sv */
// filtered shift pulse generator for programming mode
`timescale 1ns/1ps
`include "stepper_defines.svh"
module prog_pulse_gen #(
    parameter int LOW_CYCLES = `PROT_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic all_low,
    output logic      shift_pulse
);
    localparam int CW = $clog2(LOW_CYCLES + 1);

    // refuse a filter too short to count
    if (LOW_CYCLES < 2)
    begin : g_bad_len
        $error("LOW_CYCLES must be at least 2");
    end

    logic [CW-1:0] low_cnt;  // cycles spent all-low
    logic          armed;    // a phase went high since last pulse

    // count continuous all-low time, restart on any high
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            low_cnt <= '0;
        else if (!all_low)
            low_cnt <= '0;
        else if (low_cnt != CW'(LOW_CYCLES))
            low_cnt <= low_cnt + CW'(1);
    end

    // one pulse per all-low period, rearm on a high
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            armed       <= 1'b1;
            shift_pulse <= 1'b0;
        end
        else if (!all_low)
        begin
            armed       <= 1'b1;
            shift_pulse <= 1'b0;
        end
        else if (armed && low_cnt == CW'(LOW_CYCLES - 1))
        begin
            armed       <= 1'b0;
            shift_pulse <= 1'b1;
        end
        else
            shift_pulse <= 1'b0;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_short_glitch: assert property (shift_pulse |-> $past(all_low, LOW_CYCLES - 1))
        else $error("shift pulse without a full all-low interval");
    chk_single_pulse: assert property (shift_pulse ##1 all_low[*4] |-> !shift_pulse)
        else $error("second shift pulse without a phase going high");
endmodule // prog_pulse_gen

/* File: rtl/stepper_core.sv */
// stepper input decoder, configuration register, chopper and apb slave
`timescale 1ns/1ps
`include "stepper_defines.svh"
module stepper_core #(
    parameter int OSC_CYCLES = `OSC_CYCLES,
    parameter int LOW_CYCLES = `PROT_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        phase_input_one,
    input  wire logic        phase_input_two,
    input  wire logic        phase_input_three,
    input  wire logic        phase_input_four,
    input  wire logic        reduce_current_data_pin,
    input  wire logic        loop_select_data_pin,
    input  wire logic        oscillator_timing_pin_low,
    input  wire logic        over_temp,
    input  wire logic        current_at_threshold,
    output logic             winding_output_one,
    output logic             winding_output_two,
    output logic             winding_output_three,
    output logic             winding_output_four,
    output logic             high_side_switch,
    output logic             reduced_current,
    output logic      [1:0]  ref_level_code
);
    localparam int CW    = $clog2(OSC_CYCLES);
    localparam int ON75  = OSC_CYCLES * 3 / 4;
    localparam int ON50  = OSC_CYCLES / 2;

    // refuse an oscillator period the on-time split cannot serve
    if (OSC_CYCLES < 8)
    begin : g_bad_osc
        $error("OSC_CYCLES must be at least 8");
    end

    // swap each winding with its pair for freewheeling
    function automatic stepper_pkg::lowside_t pair_of(input stepper_pkg::lowside_t p);
        pair_of = {p[2], p[3], p[0], p[1]};
    endfunction

    logic [3:0]            in_vec;        // phase inputs, bit 0 is input one
    logic                  prog_mode;     // all phase inputs low
    logic                  shift_pulse;   // filtered programming clock
    logic [5:0]            cfg;           // six-bit configuration memory
    logic                  inhibit;       // software inhibit
    logic                  full_mode;     // full decoding selected
    stepper_pkg::lowside_t pattern;       // decoded low-side pattern
    stepper_pkg::lowside_t last_pattern;  // pattern of previous cycle
    logic                  prohibited;    // illegal full-mode inputs
    logic                  enabled;       // simplified-mode enable
    logic                  reduce;        // reduced current requested
    logic                  open_loop;     // fixed on-time chopping
    logic [1:0]            ontime_code;   // {hi, lo} on-time bits
    logic                  disable_out;   // power section off
    logic                  phase_change;  // new phase pattern
    logic [CW-1:0]         osc_cnt;       // oscillator period counter
    logic                  osc_wrap;      // end of oscillator period
    logic                  div_half;      // half-rate divider
    logic                  chop_set;      // set pulse for flip-flop
    logic                  chop_clr;      // reset condition
    stepper_pkg::chop_e    chop;          // high-side flip-flop
    logic                  local_rst;     // timing pin forced reset
    logic                  apb_access;    // completing access
    stepper_pkg::lowside_t next_low;      // next low-side drive

    assign in_vec    = {phase_input_four, phase_input_three, phase_input_two, phase_input_one};
    assign prog_mode = (in_vec == 4'h0);
    assign local_rst = oscillator_timing_pin_low;

    // filtered programming clock
    prog_pulse_gen #(
        .LOW_CYCLES (LOW_CYCLES)
    ) u_pulse (
        .clk         (clk),
        .rst         (rst),
        .all_low     (prog_mode),
        .shift_pulse (shift_pulse)
    );

    // configuration shift register, first bit enters bit zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cfg <= `CFG_RESET;
        else if (local_rst)
            cfg <= `CFG_RESET;
        else if (shift_pulse)
            // xor of the two data pins, pulse already proves the all-low window
            cfg <= {cfg[4:0], reduce_current_data_pin ^ loop_select_data_pin};
    end

    assign full_mode   = cfg[`CFG_DECODE];
    assign open_loop   = loop_select_data_pin;
    assign ontime_code = {cfg[`CFG_ONTIME_HI], cfg[`CFG_ONTIME_LO]};

    // input decoding per configured mode
    always_comb
    begin
        if (full_mode)
        begin
            // each input drives its own switch, on when low
            pattern    = ~in_vec;
            prohibited = (!in_vec[0] && !in_vec[1]) || (!in_vec[2] && !in_vec[3]);
            enabled    = 1'b1;
            reduce     = (in_vec[0] && in_vec[1]) || (in_vec[2] && in_vec[3]) || reduce_current_data_pin;
        end
        else
        begin
            // phase a on inputs one, phase b on two
            pattern    = {~in_vec[1], in_vec[1], ~in_vec[0], in_vec[0]};
            prohibited = 1'b0;
            enabled    = in_vec[2];
            reduce     = !in_vec[3] || reduce_current_data_pin;
        end
    end

    // every reason to turn the power section off except the timing pin reset, which clears the outputs on its own
    always_comb
    begin
        disable_out = inhibit || over_temp || prog_mode;
        if (prohibited || !enabled)
            disable_out = 1'b1;
        if (open_loop && ontime_code == 2'b11)
            disable_out = 1'b1;
    end

    // remember last pattern for phase change detection
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            last_pattern <= '0;
        else
            last_pattern <= pattern;
    end

    assign phase_change = !prog_mode && (pattern != last_pattern);
    assign osc_wrap     = (osc_cnt == CW'(OSC_CYCLES - 1));

    // oscillator period counter, restarted by a phase change
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            osc_cnt <= '0;
        else if (local_rst || phase_change || osc_wrap)
            osc_cnt <= '0;
        else
            osc_cnt <= osc_cnt + CW'(1);
    end

    // half-rate divider for the lower closed-loop frequency
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            div_half <= 1'b0;
        else if (local_rst || phase_change)
            div_half <= 1'b0;
        else if (osc_wrap)
            div_half <= !div_half;
    end

    // set pulse: every period, every other in low closed-loop rate
    always_comb
    begin
        chop_set = phase_change;
        if (osc_wrap)
        begin
            if (open_loop || !cfg[`CFG_CHOP_FREQ])
                chop_set = 1'b1;
            else
                chop_set = div_half;
        end
    end

    // reset condition: comparator or end of fixed on-time
    always_comb
    begin
        chop_clr = 1'b0;
        if (!open_loop)
            chop_clr = current_at_threshold;
        else
        begin
            unique case (ontime_code)
                2'b00: chop_clr = (osc_cnt == CW'(ON75 - 1));
                2'b10: chop_clr = (osc_cnt == CW'(ON50 - 1));
                2'b01: chop_clr = 1'b0;
                2'b11: chop_clr = 1'b1;
            endcase
        end
    end

    // high-side set/reset flip-flop, set wins over reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            chop <= stepper_pkg::chop_off;
        else if (local_rst || disable_out)
            chop <= stepper_pkg::chop_off;
        else if (chop_set)
            chop <= stepper_pkg::chop_on;
        else if (chop_clr)
            chop <= stepper_pkg::chop_off;
    end

    // low-side drive, paired switch added during off time
    always_comb
    begin
        if (disable_out)
            next_low = '0;
        else if (chop == stepper_pkg::chop_on)
            next_low = pattern;
        else
            next_low = pattern | pair_of(pattern);
    end

    // registered power outputs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            winding_output_one   <= 1'b0;
            winding_output_two   <= 1'b0;
            winding_output_three <= 1'b0;
            winding_output_four  <= 1'b0;
            high_side_switch     <= 1'b0;
        end
        else if (local_rst)
        begin
            winding_output_one   <= 1'b0;
            winding_output_two   <= 1'b0;
            winding_output_three <= 1'b0;
            winding_output_four  <= 1'b0;
            high_side_switch     <= 1'b0;
        end
        else
        begin
            winding_output_one   <= next_low[0];
            winding_output_two   <= next_low[1];
            winding_output_three <= next_low[2];
            winding_output_four  <= next_low[3];
            high_side_switch     <= !disable_out && chop == stepper_pkg::chop_on;
        end
    end

    // reference selection for the comparator threshold
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reduced_current <= 1'b0;
            ref_level_code  <= 2'h0;
        end
        else
        begin
            reduced_current <= reduce && !open_loop;
            ref_level_code  <= {cfg[`CFG_REF_HI], cfg[`CFG_REF_LO]};
        end
    end

    // apb: no wait state, answer on the first access cycle
    assign apb_access = psel && penable && pready;

    // apb ready and read data
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (psel && !penable && !pready)
        begin
            pready  <= 1'b1;
            pslverr <= (paddr != `ADDR_CTRL) && (paddr != `ADDR_STATUS);
            prdata  <= 32'h0000_0000;
            if (!pwrite && paddr == `ADDR_CTRL)
                prdata[`CTRL_INHIBIT] <= inhibit;
            else if (!pwrite && paddr == `ADDR_STATUS)
            begin
                // live configuration and power state
                prdata[5:0]             <= cfg;
                prdata[`ST_PROG_MODE]   <= prog_mode;
                prdata[`ST_OUT_ENABLED] <= !disable_out;
                prdata[`ST_HIGH_SIDE]   <= high_side_switch;
                prdata[`ST_REDUCED]     <= reduced_current;
            end
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // control register write
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            inhibit <= 1'b0;
        else if (apb_access && pwrite && paddr == `ADDR_CTRL)
            inhibit <= pwdata[`CTRL_INHIBIT];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_all_off;
        !high_side_switch && !winding_output_one && !winding_output_two
            && !winding_output_three && !winding_output_four;
    endsequence

    chk_prog_disables: assert property (prog_mode |=> s_all_off)
        else $error("outputs active in programming mode");
    chk_shift_data: assert property (shift_pulse && !local_rst |=>
            cfg[0] == ($past(reduce_current_data_pin) ^ $past(loop_select_data_pin)))
        else $error("shifted bit is not the xor of data pins");
    chk_shift_order: assert property (shift_pulse && !local_rst |=> cfg[5:1] == $past(cfg[4:0]))
        else $error("configuration did not shift toward bit five");
    chk_overheat_off: assert property (over_temp || inhibit |=> s_all_off)
        else $error("outputs active while inhibited or overheated");
    chk_pin_reset: assert property (local_rst |=> s_all_off and (cfg == 6'h00))
        else $error("timing pin reset did not clear state");
    chk_prohibit_off: assert property (full_mode && !in_vec[0] && !in_vec[1] |=> s_all_off)
        else $error("prohibited input combination drove outputs");
    chk_comp_reset: assert property (!open_loop && current_at_threshold && !chop_set
            && chop == stepper_pkg::chop_on |=> chop == stepper_pkg::chop_off)
        else $error("comparator did not turn the high side off");
    chk_phase_sync: assert property (phase_change && !local_rst && !disable_out
            |=> osc_cnt == '0 && chop == stepper_pkg::chop_on)
        else $error("phase change did not restart chopping");
    chk_freewheel: assert property (!disable_out && !local_rst && chop == stepper_pkg::chop_off
            && full_mode |=> winding_output_one == winding_output_two)
        else $error("paired switch not on during off time");
endmodule // stepper_core

/* File: rtl/stepper_defines.svh */
// offsets, field positions, reset values and timing counts for the stepper core
`ifndef STEPPER_DEFINES_SVH
`define STEPPER_DEFINES_SVH

// register byte offsets
`define ADDR_CTRL        12'h000
`define ADDR_STATUS      12'h004
// control fields and reset value
`define CTRL_INHIBIT     0
`define CTRL_RESET       32'h0000_0000
// status fields
`define ST_PROG_MODE     6
`define ST_OUT_ENABLED   7
`define ST_HIGH_SIDE     8
`define ST_REDUCED       9
// configuration bit positions
`define CFG_REF_LO       0
`define CFG_REF_HI       1
`define CFG_ONTIME_LO    2
`define CFG_ONTIME_HI    3
`define CFG_CHOP_FREQ    4
`define CFG_DECODE       5
`define CFG_RESET        6'h00
// timing
`define CLK_MHZ          200
`define PROT_TIME_NS     200
`define PROT_CYCLES      ((`PROT_TIME_NS * `CLK_MHZ + 999) / 1000)
`define OSC_FREQ_HZ      20000
`define OSC_CYCLES       (`CLK_MHZ * 1000000 / `OSC_FREQ_HZ)

`endif

/* File: rtl/stepper_pkg.sv */
// types shared by the stepper core
package stepper_pkg;
    // high-side flip-flop state
    typedef enum logic {chop_off, chop_on} chop_e;
    // four low-side gate drives, bit 0 is winding one
    typedef logic [3:0] lowside_t;
endpackage

/* File: sim/step_host_model.sv */
// microprocessor model driving the six control pins of the stepper core
`timescale 1ns/1ps
module step_host_model (
    input  wire logic clk,
    output logic      phase_one,
    output logic      phase_two,
    output logic      phase_three,
    output logic      phase_four,
    output logic      clev_data,
    output logic      loop_data
);
    // start in simplified drive, never all-low, so no stray shift after reset
    initial
    begin
        {phase_four, phase_three, phase_two, phase_one} = 4'h5;
        clev_data = 1'b0;
        loop_data = 1'b0;
    end

    // change all pins just after a rising edge; phases as {four,three,two,one}
    task automatic drive(input logic [3:0] ph, input logic clev, input logic loop);
        @(posedge clk);
        {phase_four, phase_three, phase_two, phase_one} <= ph;
        clev_data <= clev;
        loop_data <= loop;
    endtask

    // one serial bit: data pins xor to the bit, held over the whole low window
    task automatic send_bit(input logic b, input logic swap, input int low_cycles);
        drive(4'h0, b ^ swap, swap);
        repeat (low_cycles) @(posedge clk);
        drive(4'h1, b ^ swap, swap);
        repeat (2) @(posedge clk);
    endtask
endmodule // step_host_model

/* File: sim/unipolar_stepper_input_and_chopper_logic_test.sv */
// self-checking bench for the stepper core
`timescale 1ns/1ps
module unipolar_stepper_input_and_chopper_logic_test;
    localparam int OSC = 40;           // shortened chop period
    logic        clk       = 1'b0;     // 200 MHz clock
    logic        rst       = 1'b1;     // async reset
    logic [11:0] paddr     = 12'h000;  // apb address
    logic        psel      = 1'b0;     // apb select
    logic        penable   = 1'b0;     // apb access phase
    logic        pwrite    = 1'b0;     // apb direction
    logic [31:0] pwdata    = 32'h0;    // apb write data
    logic [31:0] prdata;               // apb read data
    logic        pready;               // apb ready
    logic        pslverr;              // apb error
    logic        ph1, ph2, ph3, ph4;   // phase pins from the host
    logic        clev, oplo;           // data pins from the host
    logic        rc_low    = 1'b0;     // timing pin pulled low
    logic        over_temp = 1'b0;     // overheat flag
    logic        cur_hit   = 1'b0;     // comparator output
    logic        w1, w2, w3, w4, hs;   // power switch drives
    logic        red;                  // reduced level chosen
    logic [1:0]  ref_code;             // reduced level code
    logic [31:0] rd;                   // last read data
    logic        err;                  // last slave error
    int          err_count = 0;        // mismatches seen
    int          samples_checked = 0;  // comparisons made
    int          cycles = 0;           // timeout counter
    int          on_count;             // high side on cycles

    // clock, 5 ns period
    always #2.5 clk = ~clk;

    step_host_model i_host (
        .clk(clk), .phase_one(ph1), .phase_two(ph2), .phase_three(ph3),
        .phase_four(ph4), .clev_data(clev), .loop_data(oplo)
    );

    stepper_core #(.OSC_CYCLES(OSC), .LOW_CYCLES(40)) i_dut (
        .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phase_input_one(ph1), .phase_input_two(ph2),
        .phase_input_three(ph3), .phase_input_four(ph4),
        .reduce_current_data_pin(clev), .loop_select_data_pin(oplo),
        .oscillator_timing_pin_low(rc_low), .over_temp(over_temp),
        .current_at_threshold(cur_hit), .winding_output_one(w1),
        .winding_output_two(w2), .winding_output_three(w3),
        .winding_output_four(w4), .high_side_switch(hs),
        .reduced_current(red), .ref_level_code(ref_code)
    );

    // print the verdict and stop
    task automatic tally_and_finish();
        if (err_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // cut a hang short
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // let n edges pass, then sample at the falling edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // count high-side cycles over n falling edges
    task automatic count_high(input int n);
        on_count = 0;
        repeat (n)
        begin
            @(negedge clk);
            if (hs === 1'b1)
                on_count++;
        end
    endtask

    // compare a word result
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // compare the switch drives {high, four, three, two, one}
    task automatic cmp_pins(input logic [4:0] exp);
        samples_checked++;
        if ({hs, w4, w3, w2, w1} !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: switches %b expected %b", $time, {hs, w4, w3, w2, w1}, exp);
        end
    endtask

    // read the configuration field of the status word
    task automatic cmp_cfg(input logic [5:0] exp);
        apb(1'b0, 12'h004, 32'h0);
        cmp_word(32'(rd[5:0]), 32'(exp));
    endtask

    // pulse the comparator for one cycle
    task automatic hit();
        @(posedge clk);
        cur_hit <= 1'b1;
        @(posedge clk);
        cur_hit <= 1'b0;
    endtask

    // main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        settle(0);
        cmp_pins(5'h00);
        cmp_cfg(6'h00);
        apb(1'b0, 12'h000, 32'h0);
        cmp_word(rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        cmp_word(32'(err), 32'h1);
        // simplified, closed loop, cfg zero
        i_host.drive(4'hD, 1'b0, 1'b0);
        settle(3);
        cmp_pins(5'h19);
        cmp_word(32'({red, ref_code}), 32'h0);
        hit();
        settle(2);
        cmp_pins(5'h0F);
        i_host.drive(4'hF, 1'b0, 1'b0);
        settle(3);
        cmp_pins(5'h15);
        i_host.drive(4'h7, 1'b0, 1'b0);
        settle(3);
        cmp_word(32'({red, ref_code}), 32'h4);
        // open loop, three quarters on-time
        i_host.drive(4'hD, 1'b0, 1'b1);
        settle(2);
        count_high(OSC);
        cmp_word(32'(on_count), 32'h1E);
        // programming: long low gives one shift, short low gives none
        i_host.send_bit(1'b1, 1'b0, 100);
        cmp_cfg(6'h01);
        i_host.send_bit(1'b1, 1'b1, 20);
        cmp_cfg(6'h01);
        @(posedge clk);
        rc_low <= 1'b1;
        settle(3);
        cmp_pins(5'h00);
        @(posedge clk);
        rc_low <= 1'b0;
        cmp_cfg(6'h00);
        // full mode, open loop, full on-time: bits sent 1,0,0,1,0,0
        for (int i = 0; i < 6; i++)
            i_host.send_bit(1'(6'h24 >> (5 - i)), i[0], 50);
        cmp_cfg(6'h24);
        i_host.drive(4'h5, 1'b0, 1'b1);
        settle(3);
        cmp_pins(5'h1A);
        i_host.drive(4'hC, 1'b0, 1'b1);
        settle(3);
        cmp_pins(5'h00);
        i_host.drive(4'h5, 1'b0, 1'b1);
        apb(1'b1, 12'h000, 32'h1);
        settle(3);
        cmp_pins(5'h00);
        apb(1'b0, 12'h000, 32'h0);
        cmp_word(rd, 32'h1);
        apb(1'b1, 12'h000, 32'h0);
        // high side waits for the next oscillator pulse after inhibit
        settle(OSC + 3);
        cmp_pins(5'h1A);
        @(posedge clk);
        over_temp <= 1'b1;
        settle(3);
        cmp_pins(5'h00);
        @(posedge clk);
        over_temp <= 1'b0;
        // simplified closed loop at half rate: one set every two periods
        for (int i = 0; i < 6; i++)
            i_host.send_bit(1'(6'h10 >> (5 - i)), 1'b0, 50);
        cmp_cfg(6'h10);
        i_host.drive(4'h5, 1'b0, 1'b0);
        @(posedge clk);
        cur_hit <= 1'b1;
        settle(2);
        count_high(4 * OSC);
        cmp_word(32'(on_count), 32'h2);
        @(posedge clk);
        cur_hit <= 1'b0;
        tally_and_finish();
    end
endmodule // unipolar_stepper_input_and_chopper_logic_test
